//--- shared/pled_defs.svh
// register offsets, field positions, reset values and timing counts of the led control
`ifndef PLED_DEFS_SVH
`define PLED_DEFS_SVH

// ------------------------------------------------------------
// register indices (byte address = 4 * (index + PLED_PORT_WORDS * port))
// ------------------------------------------------------------
`define PLED_FUNC_IDX       5'h1D
`define PLED_BEH_IDX        5'h1E
`define PLED_PORT_WORDS     32

// ------------------------------------------------------------
// behaviour register fields and masks, reset values, led count and function field width
// ------------------------------------------------------------
`define PLED_BEH_COMB_OFF   15
`define PLED_BEH_ACT_SPLIT  14
`define PLED_BEH_PULSE_EN   12
`define PLED_BEH_RATE_LO    10
`define PLED_BEH_STRETCH_LO 5
`define PLED_BEH_SPLIT_LO   0
`define PLED_BEH_RW_MASK    16'hDDEF
`define PLED_BEH_STRAP_MASK 16'h0DEF
`define PLED_FUNC_RESET     16'h0000
`define PLED_BEH_RESET      16'h0000
`define PLED_LEDS           4
`define PLED_FUNC_W         4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PLED_CLK_MHZ        100
`define PLED_MIN_STRETCH_MS 50
`define PLED_TICK_CYC       (`PLED_MIN_STRETCH_MS * 1000 * `PLED_CLK_MHZ / 2)
`define PLED_PULSE_HZ       5000
`define PLED_PULSE_CYC      (`PLED_CLK_MHZ * 1000000 / `PLED_PULSE_HZ)
`define PLED_PULSE_DUTY_PCT 20

`endif

//--- shared/pled_pkg.sv
// types shared by the led control
package pled_pkg;

   // ------------------------------------------------------------
   // led function codes
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      PLED_LINK_ACT      = 4'h0,
      PLED_LINK1000_ACT  = 4'h1,
      PLED_LINK100_ACT   = 4'h2,
      PLED_LINK10_ACT    = 4'h3,
      PLED_LINK100G_ACT  = 4'h4,
      PLED_LINK10G_ACT   = 4'h5,
      PLED_LINK10_100ACT = 4'h6,
      PLED_FIBER_LINKACT = 4'h7,
      PLED_DUPLEX_COL    = 4'h8,
      PLED_COLLISION     = 4'h9,
      PLED_ACTIVITY      = 4'hA,
      PLED_FIBER_ACT     = 4'hB,
      PLED_ANEG_FAULT    = 4'hC,
      PLED_SERIAL        = 4'hD,
      PLED_FORCE_OFF     = 4'hE,
      PLED_FORCE_ON      = 4'hF
   } pled_mode_type;

   typedef enum logic [1:0] {
      PLED_SPD_10   = 2'h0,
      PLED_SPD_100  = 2'h1,
      PLED_SPD_1000 = 2'h2,
      PLED_SPD_RSVD = 2'h3
   } pled_speed_type;

   typedef struct packed {
      logic       hit;
      logic       beh;
      logic [7:0] port;
   } pled_dec_type;

endpackage : pled_pkg

//--- hdl/pled_top.sv
// led indicator control: apb registers, timing and per-led function logic
`timescale 1ns/1ps
`include "pled_defs.svh"

module pled_top
   import pled_pkg::*;
#(
   parameter int NUM_PORTS    = 2,
   parameter int ADDR_W       = 12,
   parameter int TICK_CYCLES  = `PLED_TICK_CYC,
   parameter int PULSE_CYCLES = `PLED_PULSE_CYC
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     ce,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [ADDR_W-1:0]        paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     soft_reset,
   input  wire logic [15:0]              config_strap_func,
   input  wire logic [15:0]              config_strap_behav,
   input  wire logic [NUM_PORTS-1:0]     cu_link,
   input  wire logic [2*NUM_PORTS-1:0]   cu_speed,
   input  wire logic [NUM_PORTS-1:0]     fiber_link,
   input  wire logic [NUM_PORTS-1:0]     tx_act,
   input  wire logic [NUM_PORTS-1:0]     rx_act,
   input  wire logic [NUM_PORTS-1:0]     fiber_act,
   input  wire logic [NUM_PORTS-1:0]     duplex,
   input  wire logic [NUM_PORTS-1:0]     collision,
   input  wire logic [NUM_PORTS-1:0]     aneg_fault,
   output logic      [4*NUM_PORTS-1:0]   led_on,
   output logic                          serial_mode
);

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------
   localparam int PULSE_ON = PULSE_CYCLES * `PLED_PULSE_DUTY_PCT / 100;
   localparam int TICK_W   = $clog2(TICK_CYCLES + 1);
   localparam int PULSE_W  = $clog2(PULSE_CYCLES + 1);

   if (NUM_PORTS < 1 || NUM_PORTS > 255 || NUM_PORTS * `PLED_PORT_WORDS * 4 > 2 ** ADDR_W) begin : g_bad_ports
      $error("pled_top: port count does not fit the address space");
   end
   if (TICK_CYCLES < 1 || PULSE_CYCLES < 5 || ADDR_W < 7) begin : g_bad_timing
      $error("pled_top: timing or address width too small");
   end

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic pled_dec_type dec_addr(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-3:0] word;
      pled_dec_type      d;
      word   = a[ADDR_W-1:2];
      d.port = 8'(word >> 5);
      d.beh  = (word[4:0] == `PLED_BEH_IDX);
      d.hit  = (a[1:0] == 2'h0) && (int'(d.port) < NUM_PORTS)
               && (word[4:0] == `PLED_FUNC_IDX || d.beh);
      return d;
   endfunction : dec_addr

   function automatic logic speed_ok(input pled_mode_type m, input logic [1:0] s);
      logic g, h, t;
      g = (s == PLED_SPD_1000);
      h = (s == PLED_SPD_100);
      t = (s == PLED_SPD_10);
      unique case (m)
         PLED_LINK1000_ACT:  speed_ok = g;
         PLED_LINK100_ACT:   speed_ok = h;
         PLED_LINK10_ACT:    speed_ok = t;
         PLED_LINK100G_ACT:  speed_ok = h | g;
         PLED_LINK10G_ACT:   speed_ok = t | g;
         PLED_LINK10_100ACT: speed_ok = t | h;
         default:            speed_ok = 1'b1;
      endcase
   endfunction : speed_ok

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0]  func_q [NUM_PORTS];
   logic [15:0]  beh_q  [NUM_PORTS];
   logic         strap_done_q;
   pled_dec_type dec;
   logic         acc;
   logic         wr_en;
   logic [15:0]  rd_val;

   // decode follows the held address; the answer is registered a cycle later
   assign dec   = dec_addr(paddr);
   assign acc   = psel & penable;
   assign wr_en = acc & pready & pwrite & dec.hit;

   // soft_reset is deliberately absent here so settings survive it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_done_q <= 1'b0;
         for (int p = 0; p < NUM_PORTS; p++) begin
            func_q[p] <= `PLED_FUNC_RESET;
            beh_q[p]  <= `PLED_BEH_RESET;
         end
      end else if (ce) begin
         if (!strap_done_q) begin
            // straps are read once, on the first enabled edge after reset
            strap_done_q <= 1'b1;
            for (int p = 0; p < NUM_PORTS; p++) begin
               func_q[p] <= config_strap_func;
               beh_q[p]  <= config_strap_behav & `PLED_BEH_STRAP_MASK;
            end
         end else if (wr_en) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
               if (dec.port == 8'(p)) begin
                  if (dec.beh) begin
                     beh_q[p] <= pwdata[15:0] & `PLED_BEH_RW_MASK;
                  end else begin
                     func_q[p] <= pwdata[15:0];
                  end
               end
            end
         end
      end
   end

   // ports beyond the count read back zero
   always_comb begin
      rd_val = 16'h0000;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (dec.port == 8'(p)) begin
            rd_val = dec.beh ? beh_q[p] : func_q[p];
         end
      end
   end

   // ------------------------------------------------------------
   // apb slave: one wait state, answer registered
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         // low pready marks the first access edge, so each transfer is answered once
         if (acc && !pready) begin
            pready  <= 1'b1;
            pslverr <= !dec.hit;
            prdata  <= (dec.hit && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // shared timing
   // ------------------------------------------------------------
   logic [TICK_W-1:0]  tick_cnt_q;
   logic               tick;
   logic [3:0]         phase_q;
   logic [PULSE_W-1:0] pulse_cnt_q;
   logic               pulse_on_q;
   logic [1:0]         rate;
   logic [4:0]         stretch_len;
   logic               blink;

   // only the first port's copy sets the rate for every port
   assign rate        = beh_q[0][`PLED_BEH_RATE_LO +: 2];
   assign stretch_len = 5'h02 << (2'h3 - rate);
   assign blink       = phase_q[2'h3 - rate];
   // blink half period is 2^(3-rate) ticks and stretch 2^(4-rate) ticks
   assign tick        = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= '0;
         phase_q    <= 4'h0;
      end else if (ce) begin
         if (soft_reset || tick) begin
            tick_cnt_q <= '0;
         end else begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
         end
         if (soft_reset) begin
            phase_q <= 4'h0;
         end else if (tick) begin
            phase_q <= phase_q + 4'h1;
         end
      end
   end

   // one free-running pwm for all leds; only the per-port enable differs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt_q <= '0;
         pulse_on_q  <= 1'b0;
      end else if (ce) begin
         if (soft_reset || pulse_cnt_q == PULSE_W'(PULSE_CYCLES - 1)) begin
            pulse_cnt_q <= '0;
         end else begin
            pulse_cnt_q <= pulse_cnt_q + PULSE_W'(1);
         end
         pulse_on_q <= (pulse_cnt_q < PULSE_W'(PULSE_ON));
      end
   end

   // ------------------------------------------------------------
   // per-led function logic
   // ------------------------------------------------------------
   wire logic [4*NUM_PORTS-1:0] ser_req;

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      logic comb_off;
      logic split;
      logic lk;
      logic c_act;
      logic f_act;

      // activity sources after the combine and split settings
      assign comb_off = beh_q[p][`PLED_BEH_COMB_OFF];
      assign split    = beh_q[p][`PLED_BEH_ACT_SPLIT];
      assign lk       = cu_link[p] | (!comb_off & fiber_link[p]);
      assign c_act    = split ? tx_act[p] : (tx_act[p] | rx_act[p]);
      assign f_act    = split ? rx_act[p] : fiber_act[p];

      for (genvar l = 0; l < `PLED_LEDS; l++) begin : g_led
         pled_mode_type mode;
         logic          evt;
         logic [4:0]    str_q;
         logic          shown;
         logic          shown_c;
         logic          on;
         logic          serial_ok;

         assign mode      = pled_mode_type'(func_q[p][`PLED_FUNC_W*l +: `PLED_FUNC_W]);
         assign serial_ok = (p == 0) && (l < 2);

         always_comb begin
            unique case (mode)
               PLED_LINK_ACT, PLED_LINK1000_ACT, PLED_LINK100_ACT, PLED_LINK10_ACT,
               PLED_LINK100G_ACT, PLED_LINK10G_ACT, PLED_LINK10_100ACT:
                  evt = c_act | (!comb_off & f_act);
               PLED_FIBER_LINKACT, PLED_FIBER_ACT:
                  evt = f_act;
               PLED_DUPLEX_COL, PLED_COLLISION:
                  evt = collision[p];
               PLED_ACTIVITY:
                  evt = c_act;
               default:
                  evt = 1'b0;
            endcase
         end

         // stretch keeps short activity visible for the chosen time
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               str_q <= 5'h00;
            end else if (ce) begin
               if (soft_reset) begin
                  str_q <= 5'h00;
               end else if (evt) begin
                  str_q <= stretch_len;
               end else if (tick && str_q != 5'h00) begin
                  str_q <= str_q - 5'h01;
               end
            end
         end

         assign shown   = beh_q[p][`PLED_BEH_STRETCH_LO + l] ?
                          (str_q != 5'h00) : (evt & blink);
         assign shown_c = shown & !beh_q[p][`PLED_BEH_SPLIT_LO + l];

         always_comb begin
            unique case (mode)
               PLED_LINK_ACT, PLED_LINK1000_ACT, PLED_LINK100_ACT, PLED_LINK10_ACT,
               PLED_LINK100G_ACT, PLED_LINK10G_ACT, PLED_LINK10_100ACT:
                  on = lk & speed_ok(mode, cu_speed[2*p +: 2]) & !shown_c;
               PLED_FIBER_LINKACT:
                  on = fiber_link[p] & !shown_c;
               PLED_DUPLEX_COL:
                  on = duplex[p] ^ shown_c;
               PLED_COLLISION, PLED_ACTIVITY, PLED_FIBER_ACT:
                  on = shown;
               PLED_ANEG_FAULT:
                  on = aneg_fault[p];
               PLED_SERIAL:
                  on = 1'b0;
               PLED_FORCE_OFF:
                  on = 1'b0;
               PLED_FORCE_ON:
                  on = 1'b1;
            endcase
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               led_on[4*p+l] <= 1'b0;
            end else if (ce) begin
               // the pwm gates the final drive, so every function pulses alike
               led_on[4*p+l] <= on & (!beh_q[p][`PLED_BEH_PULSE_EN] | pulse_on_q);
            end
         end

         // serial code on any other led just leaves it dark
         assign ser_req[4*p+l] = serial_ok && (mode == PLED_SERIAL);
      end
   end

   // ------------------------------------------------------------
   // serial mode flag, first port leds 0 and 1 only
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_mode <= 1'b0;
      end else if (ce) begin
         // only a flag: the serial stream itself is not built in this block
         serial_mode <= |ser_req;
      end
   end

endmodule : pled_top

//--- tb/pled_props.sv
// concurrent checks on the led control ports
`timescale 1ns/1ps
`include "pled_defs.svh"
module pled_props #(
   parameter int NUM_PORTS = 2,
   parameter int ADDR_W    = 12
) (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   ce,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [ADDR_W-1:0]      paddr,
   input wire logic [31:0]            pwdata,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   input wire logic [15:0]            config_strap_func,
   input wire logic [15:0]            config_strap_behav,
   input wire logic [NUM_PORTS-1:0]   collision,
   input wire logic [NUM_PORTS-1:0]   aneg_fault,
   input wire logic [4*NUM_PORTS-1:0] led_on,
   input wire logic                   serial_mode
);
   // ------------------------------------------------------------
   // shadow of the first port's registers
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] FUNC_A = ADDR_W'(`PLED_FUNC_IDX * 4);
   localparam logic [ADDR_W-1:0] BEH_A  = ADDR_W'(`PLED_BEH_IDX * 4);
   logic        ld_q;
   logic [15:0] fsh_q;
   logic [15:0] bsh_q;
   logic        wr_s;
   assign wr_s = ce && psel && penable && pready && pwrite;
   // loads on the first enabled edge, as the straps do, so no window of stale codes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_q  <= 1'b1;
         fsh_q <= 16'h0000;
         bsh_q <= 16'h0000;
      end else if (ce) begin
         ld_q <= 1'b0;
         if (ld_q) begin
            fsh_q <= config_strap_func;
            bsh_q <= config_strap_behav & `PLED_BEH_STRAP_MASK;
         end else if (wr_s && paddr == FUNC_A) begin
            fsh_q <= pwdata[15:0];
         end else if (wr_s && paddr == BEH_A) begin
            bsh_q <= pwdata[15:0] & `PLED_BEH_RW_MASK;
         end
      end
   end
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_wait: assert property (ce && psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   chk_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("error read returned data");
   chk_rsvd_zero: assert property (pready && !pwrite && paddr[6:0] == 7'h78 |-> (prdata & 32'hFFFF2210) == 32'h0)
      else $error("reserved behaviour bits read set");
   chk_force_on: assert property (fsh_q[3:0] == 4'hF && !bsh_q[12] |=> led_on[0])
      else $error("forced-on led dark");
   chk_force_off: assert property (fsh_q[3:0] == 4'hE |=> !led_on[0])
      else $error("forced-off led lit");
   chk_serial_sel: assert property (##1 serial_mode == $past(fsh_q[3:0] == 4'hD || fsh_q[7:4] == 4'hD))
      else $error("serial mode flag wrong");
   chk_coll_mode: assert property (fsh_q[3:0] == 4'h9 && bsh_q[5] && !bsh_q[12] && collision[0] |-> ##2 led_on[0])
      else $error("collision led wrong");
   chk_aneg_mode: assert property (fsh_q[7:4] == 4'hC && !bsh_q[12] |=> led_on[1] == $past(aneg_fault[0]))
      else $error("fault led wrong");
endmodule : pled_props

bind pled_top pled_props #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W)) props_u (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .config_strap_func(config_strap_func), .config_strap_behav(config_strap_behav),
   .collision(collision), .aneg_fault(aneg_fault), .led_on(led_on), .serial_mode(serial_mode)
);

//--- tb/pled_led_board.sv
// board model of one discrete led, counting its lit cycles
`timescale 1ns/1ps
module pled_led_board (
   input  wire logic        pclk,
   input  wire logic        clr,
   input  wire logic        led,
   output logic      [15:0] on_cnt
);
   // ------------------------------------------------------------
   // lit-time counter
   // ------------------------------------------------------------
   // the eye integrates brightness, so lit share is what matters, not phase
   always_ff @(posedge pclk) begin
      if (clr) begin
         on_cnt <= 16'h0000;
      end else if (led) begin
         on_cnt <= on_cnt + 16'h0001;
      end
   end
endmodule : pled_led_board

//--- tb/pled_top_bench.sv
// self-checking bench for the led control
`timescale 1ns/1ps
`include "pled_defs.svh"
module pled_top_bench;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   localparam logic [20:0] SPD_TBL = {3'b011, 3'b101, 3'b110, 3'b001, 3'b010, 3'b100, 3'b111};
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic        pready, pslverr, serial_mode, serr, soft_reset = 1'b0, clr = 1'b0;
   logic [1:0]  cu_link = 2'h0, fiber_link = 2'h0, tx_act = 2'h0, rx_act = 2'h0, fiber_act = 2'h0;
   logic [1:0]  duplex = 2'h0, collision = 2'h0, aneg_fault = 2'h0;
   logic [3:0]  cu_speed = 4'h0;
   logic [7:0]  led_on;
   logic [15:0] on_cnt;
   int          n_fail = 0, checked = 0;
   pled_top #(.NUM_PORTS(2), .ADDR_W(12), .TICK_CYCLES(4), .PULSE_CYCLES(20)) dut_u (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .soft_reset(soft_reset), .config_strap_func(16'hEEEE), .config_strap_behav(16'hFFFF),
      .cu_link(cu_link), .cu_speed(cu_speed), .fiber_link(fiber_link), .tx_act(tx_act), .rx_act(rx_act),
      .fiber_act(fiber_act), .duplex(duplex), .collision(collision), .aneg_fault(aneg_fault),
      .led_on(led_on), .serial_mode(serial_mode));
   pled_led_board board_u (.pclk(pclk), .clr(clr), .led(led_on[0]), .on_cnt(on_cnt));
   initial begin
      forever #5 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic test_done();
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         n_fail++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // request held until the edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 32'h0, 32'h1);
      rdat = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic setr(input int p, input int b, input logic [15:0] d);
      apb(1'b1, 12'((`PLED_FUNC_IDX + b + `PLED_PORT_WORDS * p) * 4), d);
   endtask : setr
   task automatic rdck(input string nm, input int p, input int b, input logic [31:0] e);
      apb(1'b0, 12'((`PLED_FUNC_IDX + b + `PLED_PORT_WORDS * p) * 4), 16'h0000);
      chk(nm, rdat, e);
   endtask : rdck
   task automatic lck(input string nm, input int i, input logic e);
      cyc(3);
      chk(nm, {31'h0, led_on[i]}, {31'h0, e});
   endtask : lck
   task automatic probe(input logic [1:0] t, input logic [1:0] r, input int i, input logic e1, input logic e2);
      @(posedge pclk);
      tx_act <= t;
      rx_act <= r;
      @(posedge pclk);
      tx_act <= 2'h0;
      rx_act <= 2'h0;
      lck("act early", i, e1);
      cyc(18);
      lck("act late", i, e2);
      cyc(80);
   endtask : probe
   task automatic count(input int n, input logic [15:0] e);
      @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      cyc(n + 1);
      chk("lit cycles", {16'h0, on_cnt}, {16'h0, e});
   endtask : count
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      for (int p = 0; p < 2; p++) begin
         rdck("func strap", p, 0, 32'h0000EEEE);
         rdck("behav strap", p, 1, 32'h00000DEF);
      end
      apb(1'b0, 12'h010, 16'h0000);
      chk("unmapped data", rdat, 32'h0);
      apb(1'b1, 12'h010, 16'hFFFF);
      chk("unmapped err", {31'h0, serr}, 32'h1);
      setr(1, 1, 16'hFFFF);
      rdck("behav rw", 1, 1, 32'h0000DDEF);
      setr(1, 0, 16'h1234);
      soft_reset <= 1'b1;
      @(posedge pclk);
      soft_reset <= 1'b0;
      rdck("func sticky", 1, 0, 32'h00001234);
      rdck("behav sticky", 1, 1, 32'h0000DDEF);
      setr(0, 1, 16'h800F);
      setr(0, 0, 16'hEFEF);
      cyc(3);
      chk("field map", {28'h0, led_on[3:0]}, 32'h5);
      setr(0, 0, 16'hFEFE);
      cyc(3);
      chk("field map", {28'h0, led_on[3:0]}, 32'hA);
      cu_link <= 2'h1;
      for (int c = 0; c < 7; c++) begin
         setr(0, 0, {12'hEEE, 4'(c)});
         for (int s = 0; s < 3; s++) begin
            cu_speed <= {2'h0, 2'(s)};
            lck("speed link", 0, SPD_TBL[3*c+s]);
         end
      end
      cu_link <= 2'h0;
      lck("no link", 0, 1'b0);
      fiber_link <= 2'h1;
      setr(0, 0, 16'hEEE0);
      lck("copper only", 0, 1'b0);
      setr(0, 1, 16'h000F);
      lck("combined", 0, 1'b1);
      setr(0, 0, 16'hEEE7);
      lck("fiber link", 0, 1'b1);
      fiber_link <= 2'h0;
      ce <= 1'b0;
      lck("ce frozen", 0, 1'b1);
      ce <= 1'b1;
      lck("fiber down", 0, 1'b0);
      duplex <= 2'h1;
      collision <= 2'h1;
      setr(0, 0, 16'hEEC8);
      aneg_fault <= 2'h1;
      lck("duplex only", 0, 1'b1);
      chk("fault led", {31'h0, led_on[1]}, 32'h1);
      // stretch keeps the overlay steady; a blink phase would make the result a gamble
      setr(0, 1, 16'h0020);
      lck("duplex col", 0, 1'b0);
      setr(0, 0, 16'hEEE9);
      lck("collision", 0, 1'b1);
      collision <= 2'h0;
      setr(0, 0, 16'hEEEA);
      setr(1, 0, 16'hEEEA);
      setr(0, 1, 16'h0C20);
      setr(1, 1, 16'h0020);
      probe(2'h1, 2'h0, 0, 1'b1, 1'b0);
      probe(2'h2, 2'h0, 4, 1'b1, 1'b0);
      setr(0, 1, 16'h0020);
      setr(1, 1, 16'h0C20);
      probe(2'h1, 2'h0, 0, 1'b1, 1'b1);
      probe(2'h2, 2'h0, 4, 1'b1, 1'b1);
      setr(0, 1, 16'h4C20);
      probe(2'h0, 2'h1, 0, 1'b0, 1'b0);
      setr(0, 0, 16'hEEEB);
      probe(2'h0, 2'h1, 0, 1'b1, 1'b0);
      setr(0, 1, 16'h0C20);
      fiber_act <= 2'h1;
      lck("fiber act", 0, 1'b1);
      fiber_act <= 2'h0;
      setr(0, 0, 16'hEEEA);
      setr(0, 1, 16'h0C00);
      tx_act <= 2'h1;
      count(64, 16'd32);
      setr(0, 1, 16'h0C20);
      count(64, 16'd64);
      tx_act <= 2'h0;
      setr(0, 1, 16'h1000);
      setr(0, 0, 16'hEEEF);
      count(200, 16'd40);
      setr(0, 1, 16'h0000);
      setr(0, 0, 16'hEEED);
      lck("serial dark", 0, 1'b0);
      chk("serial on", {31'h0, serial_mode}, 32'h1);
      setr(0, 0, 16'hEDEE);
      setr(1, 0, 16'hEEED);
      cyc(3);
      chk("serial off", {31'h0, serial_mode}, 32'h0);
      test_done();
   end
endmodule : pled_top_bench
